// *** hw/fcs_pkg.sv ***
package fcs_pkg;
	// Configuration register fields
	localparam int          CFG_W          = 8;
	localparam logic [7:0]  CFG_RESET      = 8'h00;
	localparam int          CLK_RATE_BIT   = 0;
	localparam int          PKG_SIZE_BIT   = 1;
	localparam int          GAP_BIT        = 2;
	localparam int          WSET_LSB       = 3;
	localparam int          WSET_MSB       = 4;
	localparam int          POL_BIT        = 5;
	// Position of the enable bit in the global settings register
	localparam int          ENABLE_BIT     = 6;

	// Word layout
	localparam int          SAMPLE_W       = 24;
	localparam int          WORD_W         = 32;
	localparam int          NUM_VALUES     = 15;
	localparam int          NUM_SLOTS      = 16;
	localparam logic [3:0]  FIRST_SLOT     = 4'h0;
	localparam logic [3:0]  ZERO_SLOT      = 4'h6;
	localparam logic [3:0]  FIRST_POWER    = 4'h7;
	localparam logic [3:0]  LAST_SLOT      = 4'hf;
	localparam logic [4:0]  LAST_BIT       = 5'h1f;
	localparam logic [2:0]  LAST_BYTE_BIT  = 3'h7;

	// Timing
	localparam int          MCLK_MHZ       = 250;
	localparam int          RATE_FAST_MHZ  = 8;
	localparam int          RATE_SLOW_MHZ  = 4;
	localparam int          SAMPLE_PERIOD_US = 125;
	localparam int          GAP_CYCLES     = 7;
	// Accumulator steps: two link edges per link period
	localparam logic [7:0]  ACC_MOD        = 8'(MCLK_MHZ);
	localparam logic [7:0]  STEP_FAST      = 8'(2 * RATE_FAST_MHZ);
	localparam logic [7:0]  STEP_SLOW      = 8'(2 * RATE_SLOW_MHZ);
	localparam logic [3:0]  GAP_HALVES     = 4'(2 * GAP_CYCLES);

	typedef enum logic [1:0]
	{
		FCS_WSET_ALL     = 2'b00,
		FCS_WSET_SAMPLES = 2'b01,
		FCS_WSET_POWERS  = 2'b10,
		FCS_WSET_RSVD    = 2'b11
	} fcs_wset_t;

	typedef enum logic [1:0]
	{
		FCS_IDLE  = 2'b00,
		FCS_SHIFT = 2'b01,
		FCS_GAP   = 2'b10
	} fcs_state_t;
endpackage : fcs_pkg

// *** hw/fcs_tx.sv ***
`timescale 1ns/100ps

// Overview of operation
// RULE1 - Idle after reset; runs only while enabled
// RULE2 - Enable ignored unless I2C is host port
// RULE3 - Always master: drives select, data, clock
// RULE4 - Clock 8 MHz, or 4 MHz when rate set
// RULE5 - New data bit on each falling clock edge
// RULE6 - Slave samples data on rising clock edge
// RULE7 - 24-bit values sign-extended, sent MSB first
// RULE8 - Package size bit selects 32 or 8 bits
// RULE9 - Gap bit inserts seven idle clock cycles
// RULE10 - No gap: continuous bits, size ignored
// RULE11 - Set 00: sixteen words, samples, zero, powers
// RULE12 - Set 01: six samples then one zero
// RULE13 - Set 10: nine powers only
// RULE14 - Set 11 behaves like set 00
// RULE15 - Select asserted whole transfer, polarity bit five
// RULE16 - Reserved config bits change no behaviour
// RULE17 - Data and select pins high after reset
// RULE18 - Software configures before enabling port
// RULE19 - Send each period if fits, else alternate
// RULE20 - No gap after last package; select drops
// RULE21 - One coherent snapshot per transfer
module fcs_tx
	import fcs_pkg::*;
(
	input  wire logic                   mclk,                    // System clock, 250 MHz
	input  wire logic                   rst,                     // Asynchronous reset, active high
	input  wire logic                   capture_port_enable,     // Enable bit of global settings
	input  wire logic                   i2c_host_active,         // I2C is the active host port
	input  wire logic                   sample_strobe,           // One-cycle pulse each sample period
	input  wire logic                   cfg_wr,                  // Config write strobe
	input  wire logic [fcs_pkg::CFG_W-1:0]    cfg_wdata,         // Config write data
	output logic      [fcs_pkg::CFG_W-1:0]    cfg_rdata,         // Config readback
	input  wire logic [fcs_pkg::SAMPLE_W-1:0] phase_a_current_sample, // Waveform sample
	input  wire logic [fcs_pkg::SAMPLE_W-1:0] phase_a_voltage_sample, // Waveform sample
	input  wire logic [fcs_pkg::SAMPLE_W-1:0] phase_b_current_sample, // Waveform sample
	input  wire logic [fcs_pkg::SAMPLE_W-1:0] phase_b_voltage_sample, // Waveform sample
	input  wire logic [fcs_pkg::SAMPLE_W-1:0] phase_c_current_sample, // Waveform sample
	input  wire logic [fcs_pkg::SAMPLE_W-1:0] phase_c_voltage_sample, // Waveform sample
	input  wire logic [fcs_pkg::SAMPLE_W-1:0] phase_a_apparent_power, // Power value
	input  wire logic [fcs_pkg::SAMPLE_W-1:0] phase_b_apparent_power, // Power value
	input  wire logic [fcs_pkg::SAMPLE_W-1:0] phase_c_apparent_power, // Power value
	input  wire logic [fcs_pkg::SAMPLE_W-1:0] phase_a_active_power,   // Power value
	input  wire logic [fcs_pkg::SAMPLE_W-1:0] phase_b_active_power,   // Power value
	input  wire logic [fcs_pkg::SAMPLE_W-1:0] phase_c_active_power,   // Power value
	input  wire logic [fcs_pkg::SAMPLE_W-1:0] phase_a_reactive_power, // Power value
	input  wire logic [fcs_pkg::SAMPLE_W-1:0] phase_b_reactive_power, // Power value
	input  wire logic [fcs_pkg::SAMPLE_W-1:0] phase_c_reactive_power, // Power value
	output logic                        capture_select_out,      // Select, polarity per config
	output logic                        capture_data_out,        // Serial data
	output logic                        capture_serial_clock,    // Serial clock, idles high
	output logic                        transfer_busy            // High while a transfer runs
);
	import fcs_pkg::*;

	logic [CFG_W-1:0]  cfg_reg;
	logic [CFG_W-1:0]  xcfg_reg;
	fcs_state_t        state_reg;
	fcs_state_t        state_next;
	logic [7:0]        acc_reg;
	logic [3:0]        slot_reg;
	logic [4:0]        bit_reg;
	logic [3:0]        gap_reg;
	logic              sclk_reg;
	logic              data_reg;
	logic              sel_reg;
	logic              end_reg;
	logic [WORD_W-1:0] snap_reg [NUM_SLOTS];

	logic [SAMPLE_W-1:0] values [NUM_VALUES];
	logic [WORD_W-1:0]   slot_word [NUM_SLOTS];

	assign values[0]  = phase_a_current_sample;
	assign values[1]  = phase_a_voltage_sample;
	assign values[2]  = phase_b_current_sample;
	assign values[3]  = phase_b_voltage_sample;
	assign values[4]  = phase_c_current_sample;
	assign values[5]  = phase_c_voltage_sample;
	assign values[6]  = phase_a_apparent_power;
	assign values[7]  = phase_b_apparent_power;
	assign values[8]  = phase_c_apparent_power;
	assign values[9]  = phase_a_active_power;
	assign values[10] = phase_b_active_power;
	assign values[11] = phase_c_active_power;
	assign values[12] = phase_a_reactive_power;
	assign values[13] = phase_b_reactive_power;
	assign values[14] = phase_c_reactive_power;

	// Slot 6 is the constant zero word between samples and powers
	genvar gi;
	generate
		for (gi = 0; gi < NUM_SLOTS; gi++)
		begin : g_slot
			if (gi < 6)
			begin : g_smp
				assign slot_word[gi] = {{(WORD_W-SAMPLE_W){values[gi][SAMPLE_W-1]}}, values[gi]}; // [RULE7] [RULE11]
			end
			else if (gi == 6)
			begin : g_zero
				assign slot_word[gi] = '0; // [RULE11] [RULE12]
			end
			else
			begin : g_pwr
				assign slot_word[gi] = {{(WORD_W-SAMPLE_W){values[gi-1][SAMPLE_W-1]}}, values[gi-1]}; // [RULE7]
			end
		end
	endgenerate

	// Word-set decode, used for both start and end slot
	function automatic logic [3:0] first_slot(input logic [1:0] ws);
		first_slot = (fcs_wset_t'(ws) == FCS_WSET_POWERS) ? FIRST_POWER : FIRST_SLOT; // [RULE13]
	endfunction : first_slot

	function automatic logic [3:0] last_slot(input logic [1:0] ws);
		// Reserved code falls through to the full set
		last_slot = (fcs_wset_t'(ws) == FCS_WSET_SAMPLES) ? ZERO_SLOT : LAST_SLOT; // [RULE12] [RULE14]
	endfunction : last_slot

	// Only I2C hosting unlocks the port
	wire         run_en     = capture_port_enable & i2c_host_active; // [RULE1] [RULE2]
	wire         start      = (state_reg == FCS_IDLE) & run_en & sample_strobe; // [RULE19] [RULE21]
	wire [7:0]   step       = xcfg_reg[CLK_RATE_BIT] ? STEP_SLOW : STEP_FAST; // [RULE4]
	wire [8:0]   acc_sum    = {1'b0, acc_reg} + {1'b0, step};
	// Fractional divider: 250 is not a multiple of 16, edges dither by one mclk
	wire         tick       = (acc_sum >= {1'b0, ACC_MOD}); // [RULE4]
	wire [7:0]   acc_wrap   = tick ? 8'(acc_sum - {1'b0, ACC_MOD}) : acc_sum[7:0];
	wire         fall       = tick & sclk_reg & (state_reg == FCS_SHIFT); // [RULE5]
	wire         rise       = tick & ~sclk_reg & (state_reg == FCS_SHIFT); // [RULE6]
	wire         word_end   = (bit_reg == LAST_BIT);
	wire         last_pkg   = word_end & (slot_reg == last_slot(xcfg_reg[WSET_MSB:WSET_LSB])); // [RULE20]
	wire         pkg_end    = xcfg_reg[PKG_SIZE_BIT] ? (bit_reg[2:0] == LAST_BYTE_BIT) : word_end; // [RULE8]
	wire         take_gap   = xcfg_reg[GAP_BIT] & pkg_end & ~last_pkg; // [RULE9] [RULE10] [RULE20]
	wire         gap_done   = tick & (gap_reg == 4'h1);
	wire [WORD_W-1:0] cur_word = snap_reg[slot_reg];
	wire         cur_bit    = cur_word[5'(LAST_BIT - bit_reg)]; // [RULE7]
	wire         sel_active = (state_next != FCS_IDLE);

	always_comb
	begin
		state_next = state_reg;
		unique case (state_reg)
			FCS_IDLE:
			begin
				if (start)
					state_next = FCS_SHIFT;
			end
			FCS_SHIFT:
			begin
				if (!run_en)
					state_next = FCS_IDLE; // [RULE1]
				else if (end_reg)
					state_next = FCS_IDLE; // [RULE20]
				else if (rise && take_gap)
					state_next = FCS_GAP; // [RULE9]
			end
			FCS_GAP:
			begin
				if (!run_en)
					state_next = FCS_IDLE;
				else if (gap_done)
					state_next = FCS_SHIFT;
			end
			default:
				state_next = FCS_IDLE;
		endcase
	end

	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
			cfg_reg <= CFG_RESET;
		else if (cfg_wr)
			cfg_reg <= cfg_wdata; // [RULE16]
	end

	assign cfg_rdata = cfg_reg;

	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
			xcfg_reg <= CFG_RESET;
		else if (start)
			xcfg_reg <= cfg_reg; // Config except select polarity is frozen for a whole transfer
	end

	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
			state_reg <= FCS_IDLE; // [RULE1]
		else
			state_reg <= state_next;
	end

	// End one mclk after the last rising edge, so that select and data hold through the slave's sample
	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
			end_reg <= 1'b0;
		else
			end_reg <= rise & last_pkg; // [RULE20]
	end

	generate
		for (gi = 0; gi < NUM_SLOTS; gi++)
		begin : g_snap
			always_ff @(posedge mclk or posedge rst)
			begin
				if (rst)
					snap_reg[gi] <= '0;
				else if (start)
					snap_reg[gi] <= slot_word[gi]; // [RULE21]
			end
		end
	endgenerate

	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
			acc_reg <= '0;
		else if (start)
			acc_reg <= '0;
		else if (state_reg != FCS_IDLE)
			acc_reg <= acc_wrap; // [RULE4]
	end

	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
			sclk_reg <= 1'b1;
		else if (state_next != FCS_SHIFT)
			sclk_reg <= 1'b1;
		else if (tick && state_reg == FCS_SHIFT)
			sclk_reg <= ~sclk_reg; // [RULE3] [RULE4]
	end

	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
			slot_reg <= FIRST_SLOT;
		else if (start)
			slot_reg <= first_slot(cfg_reg[WSET_MSB:WSET_LSB]); // [RULE11] [RULE13] [RULE14]
		else if (rise && word_end && !last_pkg)
			slot_reg <= 4'(slot_reg + 4'h1);
	end

	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
			bit_reg <= '0;
		else if (start)
			bit_reg <= '0;
		else if (rise)
			bit_reg <= 5'(bit_reg + 5'h1);
	end

	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
			gap_reg <= '0;
		else if (rise && take_gap)
			gap_reg <= GAP_HALVES; // [RULE9]
		else if (tick && state_reg == FCS_GAP)
			gap_reg <= 4'(gap_reg - 4'h1);
	end

	// Data holds its last bit through gaps and idles high between transfers
	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
			data_reg <= 1'b1; // [RULE17]
		else if (state_next == FCS_IDLE)
			data_reg <= 1'b1;
		else if (fall)
			data_reg <= cur_bit; // [RULE5] [RULE10]
	end

	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
			sel_reg <= 1'b1; // [RULE17]
		else
			sel_reg <= sel_active ^ ~cfg_reg[POL_BIT]; // [RULE15]
	end

	assign capture_select_out   = sel_reg;
	assign capture_data_out     = data_reg;
	assign capture_serial_clock = sclk_reg;
	assign transfer_busy        = (state_reg != FCS_IDLE);
endmodule : fcs_tx

// *** tb/fast_capture_serial_tx_tb.sv ***
`timescale 1ns/100ps
module fast_capture_serial_tx_tb;
	import fcs_pkg::*;
	logic        mclk = 1'b0;
	logic        rst = 1'b1;
	logic        en = 1'b0;
	logic        i2c = 1'b1;
	logic        strobe = 1'b0;
	logic        cfg_wr = 1'b0;
	logic [7:0]  cfg_wdata = 8'h00;
	logic        flip = 1'b0;
	logic [7:0]  cfg_rdata;
	logic        sel, dat, sclk, busy;
	logic [23:0] val [15];
	int          n_fail = 0;
	int          check_count = 0;
	always #2 mclk = ~mclk;
	function automatic logic [23:0] base(input int k);
		return {k[0], 7'(k), 16'h5a00 + 16'(k)};
	endfunction : base
	function automatic logic [31:0] exp_word(input int s);
		logic [23:0] b;
		b = base(s < 6 ? s : s - 1);
		return (s == 6) ? 32'h0 : {{8{b[23]}}, b};
	endfunction : exp_word
	// Inputs move during a transfer; the sent words must not follow them
	always_comb
		for (int k = 0; k < 15; k++)
			val[k] = base(k) ^ {24{flip}};
	fcs_tx fcs_tx_inst (.mclk, .rst, .capture_port_enable(en), .i2c_host_active(i2c), .sample_strobe(strobe),
		.cfg_wr, .cfg_wdata, .cfg_rdata, .phase_a_current_sample(val[0]), .phase_a_voltage_sample(val[1]),
		.phase_b_current_sample(val[2]), .phase_b_voltage_sample(val[3]), .phase_c_current_sample(val[4]),
		.phase_c_voltage_sample(val[5]), .phase_a_apparent_power(val[6]), .phase_b_apparent_power(val[7]),
		.phase_c_apparent_power(val[8]), .phase_a_active_power(val[9]), .phase_b_active_power(val[10]),
		.phase_c_active_power(val[11]), .phase_a_reactive_power(val[12]), .phase_b_reactive_power(val[13]),
		.phase_c_reactive_power(val[14]), .capture_select_out(sel), .capture_data_out(dat),
		.capture_serial_clock(sclk), .transfer_busy(busy));
	fcs_rx_model fcs_rx_model_inst (.sclk(sclk), .sdata(dat), .sel(sel), .pol(cfg_rdata[POL_BIT]));
	task automatic check(input logic [31:0] got, input logic [31:0] want);
		check_count++;
		if (got !== want)
		begin
			n_fail++;
			$display("wrong value at %0t: got %h expected %h", $time, got, want);
		end
	endtask : check
	task automatic pulse();
		@(negedge mclk);
		strobe = 1'b1;
		@(negedge mclk);
		strobe = 1'b0;
	endtask : pulse
	task automatic run(input logic [7:0] c, input int first, input int n);
		int i;
		en = 1'b0;
		@(negedge mclk);
		cfg_wr = 1'b1;
		cfg_wdata = c;
		@(negedge mclk);
		cfg_wr = 1'b0;
		en = 1'b1;
		@(negedge mclk);
		check({24'h0, cfg_rdata}, {24'h0, c});
		fcs_rx_model_inst.words.delete();
		pulse();
		for (i = 0; i < 100 && busy !== 1'b1; i++)
			@(negedge mclk);
		flip = 1'b1;
		repeat (3000) @(negedge mclk);
		pulse();
		for (i = 0; i < 40000 && busy !== 1'b0; i++)
			@(negedge mclk);
		flip = 1'b0;
		check(32'(fcs_rx_model_inst.words.size()), 32'(n));
		for (i = 0; i < n; i++)
			check(fcs_rx_model_inst.words[i], exp_word(first + i));
	endtask : run
	task automatic give_verdict();
		$display("checks %0d, mismatches %0d", check_count, n_fail);
		if (n_fail == 0 && check_count > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : give_verdict
	initial
	begin
		#400000;
		n_fail++;
		give_verdict();
	end
	initial
	begin
		repeat (10) @(negedge mclk);
		rst = 1'b0;
		@(negedge mclk);
		check({30'h0, sel, dat}, 32'h3);
		for (int i = 0; i < 2; i++)
		begin
			en = i[0];
			i2c = !i[0];
			pulse();
			repeat (4) @(negedge mclk);
			check({31'h0, busy}, 32'h0);
		end
		i2c = 1'b1;
		run(8'h00, 0, 16);
		run(8'hee, 0, 7);
		run(8'h11, 7, 9);
		run(8'h1c, 0, 16);
		give_verdict();
	end
endmodule : fast_capture_serial_tx_tb
bind fcs_tx fcs_tx_checker fcs_tx_checker_inst (.mclk, .rst, .capture_port_enable, .i2c_host_active,
	.sample_strobe, .cfg_rdata, .capture_select_out, .capture_data_out, .capture_serial_clock, .transfer_busy);

// *** tb/fcs_rx_model.sv ***
`timescale 1ns/100ps
module fcs_rx_model
(
	input wire logic sclk,  // Link clock
	input wire logic sdata, // Serial data
	input wire logic sel,   // Select
	input wire logic pol    // Active level of select
);
	logic [31:0] shift_reg = 32'h0;
	int          nbits     = 0;
	logic [31:0] words[$];
	// Deselect restarts framing so a partial word never leaks into the next
	always @(sel)
		if (sel !== pol)
			nbits = 0;
	always @(posedge sclk)
		if (sel === pol)
		begin
			shift_reg = {shift_reg[30:0], sdata};
			nbits++;
			if (nbits == 32)
			begin
				words.push_back(shift_reg);
				nbits = 0;
			end
		end
endmodule : fcs_rx_model

// *** tb/fcs_tx_checker.sv ***
`timescale 1ns/100ps
module fcs_tx_checker
	import fcs_pkg::*;
(
	input wire logic                       mclk,                 // Clock
	input wire logic                       rst,                  // Reset
	input wire logic                       capture_port_enable,  // Enable
	input wire logic                       i2c_host_active,      // Host port
	input wire logic                       sample_strobe,        // Start
	input wire logic [fcs_pkg::CFG_W-1:0]  cfg_rdata,            // Config
	input wire logic                       capture_select_out,   // Select
	input wire logic                       capture_data_out,     // Data
	input wire logic                       capture_serial_clock, // Link clock
	input wire logic                       transfer_busy         // Busy
);
	logic [7:0] run_reg; // Cycles the link clock has been low, saturating
	wire        on_w = capture_port_enable && i2c_host_active;
	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
			run_reg <= 8'h00;
		else if (capture_serial_clock)
			run_reg <= 8'h00;
		else if (run_reg != 8'hff)
			run_reg <= run_reg + 8'h01;
	end
	default clocking @(posedge mclk); endclocking
	default disable iff (rst);
	chk_select_level: assert property ($stable(cfg_rdata) |-> capture_select_out == (transfer_busy ~^ cfg_rdata[POL_BIT]))
		else $error("select level wrong");
	chk_idle_pins: assert property (!transfer_busy |-> capture_data_out && capture_serial_clock)
		else $error("idle pins not high");
	chk_start_taken: assert property (sample_strobe && on_w && !transfer_busy |=> transfer_busy)
		else $error("strobe not taken");
	chk_start_refused: assert property (!on_w && !transfer_busy |=> !transfer_busy)
		else $error("start while disabled");
	chk_first_half: assert property ($rose(transfer_busy) |-> capture_serial_clock[*8])
		else $error("first half period not high");
	chk_data_edge: assert property (transfer_busy && $changed(capture_data_out) |-> $fell(capture_serial_clock))
		else $error("data moved off falling edge");
	chk_low_span: assert property (!capture_serial_clock |-> run_reg < 8'h20)
		else $error("link clock low too long");
	chk_end_nogap: assert property ($fell(transfer_busy) && on_w |-> capture_serial_clock && !$past(capture_serial_clock, 2))
		else $error("transfer ended late");
endmodule : fcs_tx_checker
